// >>> lss_regs.v
// link status, link control and slot capability register bank for one port
//
// Notes on behaviour
// (R1) rate field read-only, resets to one
// (R2) lane field reports negotiated width
// (R3) training failure bit, undefined in 1.1
// (R4) training bit high while training
// (R5) shared clock bit loaded from strap
// (R6) link active bit mirrors data link
// (R7) link active reads zero without capability
// (R8) retrain completion without link down sets flag
// (R9) corrective speed/width change sets flag
// (R10) both flags zero without notify capability
// (R11) compatibility mode: flags read zero
// (R12) autonomous change sets autonomous flag
// (R13) downstream: eight marked ordered sets set flag
// (R14) attention button present bit, lockable
// (R15) power controller present bit, lockable
// (R16) slot bits zero when slot absent
// (R17) write one clears flag, set wins
// (R18) retrain write starts recovery, reads zero
// (R19) bandwidth flag set raises interrupt
// (R20) autonomous flag set raises interrupt
`timescale 1ns/100ps
`include "lss_defines.vh"
module lss_regs #(
  parameter UPSTREAM = 0
) (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [31:0] reg_rdata,
  input  wire        up_port_refclk_strap,
  input  wire        down_port_refclk_strap,
  input  wire [3:0]  phy_rate,
  input  wire [5:0]  phy_lanes,
  input  wire        phy_train_error,
  input  wire        phy_training,
  input  wire        dl_active_in,
  input  wire        dl_down,
  input  wire        retrain_done,
  input  wire        phy_fix_change,
  input  wire        phy_auto_change,
  input  wire        ts_valid,
  input  wire        ts_auto_change,
  output wire        retrain_request,
  output wire        bw_mgmt_irq,
  output wire        auto_bw_irq
);

  // status mirrors
  reg [3:0]  current_rate_reg;
  reg [5:0]  negotiated_lanes_reg;
  reg        training_failure_reg;
  reg        training_active_reg;
  reg        dl_active_flag_reg;
  reg        shared_refclk_reg;
  reg [1:0]  strap_cnt_reg;

  // event flags and their bookkeeping
  reg        bw_mgmt_flag_reg;
  reg        auto_bw_flag_reg;
  reg        retrain_pending_reg;
  reg        dl_down_seen_reg;
  reg [3:0]  os_cnt_reg;

  // software state
  reg        bw_mgmt_irq_enable_reg;
  reg        auto_bw_irq_enable_reg;
  reg        attn_button_present_reg;
  reg        power_ctrl_present_reg;
  reg [`LSS_CFG_WIDTH-1:0] cfg_reg;

  // outputs
  reg        retrain_request_reg;
  reg        bw_mgmt_irq_reg;
  reg        auto_bw_irq_reg;
  reg [31:0] rd_data_reg;
  reg [31:0] rd_data_next;

  wire [1:0] strap_sync;
  wire       strap_value;
  wire       bw_notify_capable;
  wire       dl_report_capable;
  wire       slot_implemented;
  wire       compat_11;
  wire       cfg_locked;
  wire       flags_allowed;
  wire       wr_ctl;
  wire       wr_sts;
  wire       wr_slot;
  wire       wr_cfg;
  wire       bw_mgmt_set;
  wire       auto_bw_set;
  wire       bw_mgmt_clr;
  wire       auto_bw_clr;
  wire       os_eighth;
  wire       bw_irq_en_eff;
  wire       auto_irq_en_eff;
  wire [15:0] link_sts_word;
  wire [15:0] link_ctl_word;
  wire [31:0] slot_cap_word;

  // strap pins come from outside, pass two flops first
  lss_sync #(
    .WIDTH (2)
  ) u_strap_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in ({up_port_refclk_strap, down_port_refclk_strap}),
    .sync_out (strap_sync)
  );

  // port role picks which strap seeds the clock bit
  assign strap_value = (UPSTREAM != 0) ? strap_sync[1] : strap_sync[0];

  // configuration bits
  assign bw_notify_capable = cfg_reg[`LSS_CFG_BW_NOTIFY];
  assign dl_report_capable = cfg_reg[`LSS_CFG_DL_REPORT];
  assign slot_implemented  = cfg_reg[`LSS_CFG_SLOT_IMPL];
  assign compat_11         = cfg_reg[`LSS_CFG_COMPAT_11];
  assign cfg_locked        = cfg_reg[`LSS_CFG_LOCK];
  assign flags_allowed     = bw_notify_capable & ~compat_11; // R10 R11

  // write decode
  assign wr_ctl  = reg_wr & (reg_addr == `LSS_ADDR_LINK_CTRL);
  assign wr_sts  = reg_wr & (reg_addr == `LSS_ADDR_LINK_STS);
  assign wr_slot = reg_wr & (reg_addr == `LSS_ADDR_SLOT_CAP);
  assign wr_cfg  = reg_wr & (reg_addr == `LSS_ADDR_CONFIG);

  // status mirrors follow the physical and data link layers
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      current_rate_reg     <= `LSS_RATE_RESET; // R1
      negotiated_lanes_reg <= `LSS_LANES_RESET;
      training_failure_reg <= 1'b0;
      training_active_reg  <= 1'b0;
      dl_active_flag_reg   <= 1'b0;
    end else begin
      current_rate_reg     <= phy_rate; // R1
      negotiated_lanes_reg <= phy_lanes; // R2
      training_failure_reg <= phy_train_error & ~compat_11; // R3
      training_active_reg  <= phy_training; // R4
      dl_active_flag_reg   <= dl_active_in & dl_report_capable; // R6 R7
    end
  end

  // shared clock bit seeded from strap after the synchroniser settles
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strap_cnt_reg     <= 2'h0;
      shared_refclk_reg <= 1'b0;
    end else begin
      if (strap_cnt_reg != `LSS_STRAP_DONE_CNT) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
      if (strap_cnt_reg == `LSS_STRAP_LOAD_CNT) begin
        shared_refclk_reg <= strap_value; // R5
      end else if (wr_sts & ~cfg_locked & (strap_cnt_reg == `LSS_STRAP_DONE_CNT)) begin
        shared_refclk_reg <= reg_wdata[`LSS_STS_REFCLK]; // R5
      end
    end
  end

  // retrain tracking: a link down during the retrain disqualifies it
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      retrain_pending_reg <= 1'b0;
      dl_down_seen_reg    <= 1'b0;
    end else begin
      if (retrain_request_reg) begin
        retrain_pending_reg <= 1'b1;
        dl_down_seen_reg    <= 1'b0;
      end else begin
        if (retrain_done) begin
          retrain_pending_reg <= 1'b0;
        end
        if (dl_down & retrain_pending_reg) begin
          dl_down_seen_reg <= 1'b1;
        end
      end
    end
  end

  // consecutive marked ordered sets on a downstream port
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      os_cnt_reg <= 4'h0;
    end else if (ts_valid) begin
      if (!ts_auto_change) begin
        os_cnt_reg <= 4'h0; // R13
      end else if (os_cnt_reg != `LSS_AUTO_OS_COUNT) begin
        os_cnt_reg <= os_cnt_reg + 4'h1; // R13
      end
    end
  end

  assign os_eighth = (UPSTREAM == 0) & ts_valid & ts_auto_change &
                     (os_cnt_reg == (`LSS_AUTO_OS_COUNT - 4'h1)); // R13

  // set events for the two bandwidth flags
  assign bw_mgmt_set = flags_allowed &
                       ((retrain_done & retrain_pending_reg & ~dl_down_seen_reg & ~dl_down) | // R8
                        (phy_fix_change & ~dl_down)); // R9
  assign auto_bw_set = flags_allowed & ((phy_auto_change & ~dl_down) | os_eighth); // R12 R13

  // write one to clear
  assign bw_mgmt_clr = wr_sts & reg_wdata[`LSS_STS_BW_MGMT]; // R17
  assign auto_bw_clr = wr_sts & reg_wdata[`LSS_STS_AUTO_BW]; // R17

  // flags: set beats clear, forced low when not allowed
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bw_mgmt_flag_reg <= 1'b0;
      auto_bw_flag_reg <= 1'b0;
    end else begin
      bw_mgmt_flag_reg <= flags_allowed & (bw_mgmt_set | (bw_mgmt_flag_reg & ~bw_mgmt_clr)); // R10 R11 R17
      auto_bw_flag_reg <= flags_allowed & (auto_bw_set | (auto_bw_flag_reg & ~auto_bw_clr)); // R10 R11 R17
    end
  end

  // link control: retrain strobe and interrupt enables
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      retrain_request_reg    <= 1'b0;
      bw_mgmt_irq_enable_reg <= 1'b0;
      auto_bw_irq_enable_reg <= 1'b0;
    end else begin
      retrain_request_reg <= wr_ctl & reg_wdata[`LSS_CTL_RETRAIN]; // R18
      if (wr_ctl) begin
        bw_mgmt_irq_enable_reg <= reg_wdata[`LSS_CTL_BW_IRQ_EN];
        auto_bw_irq_enable_reg <= reg_wdata[`LSS_CTL_AUTO_IRQ_EN];
      end
    end
  end

  // enables read and act as zero when flags are not allowed
  assign bw_irq_en_eff   = bw_mgmt_irq_enable_reg & flags_allowed;
  assign auto_irq_en_eff = auto_bw_irq_enable_reg & flags_allowed;

  // one-cycle interrupt pulse when a flag goes from clear to set
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bw_mgmt_irq_reg <= 1'b0;
      auto_bw_irq_reg <= 1'b0;
    end else begin
      bw_mgmt_irq_reg <= bw_irq_en_eff & bw_mgmt_set & ~bw_mgmt_flag_reg; // R19
      auto_bw_irq_reg <= auto_irq_en_eff & auto_bw_set & ~auto_bw_flag_reg; // R20
    end
  end

  // slot capability bits, writable until locked, cleared without a slot
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      attn_button_present_reg <= 1'b0;
      power_ctrl_present_reg  <= 1'b0;
    end else if (!slot_implemented) begin
      attn_button_present_reg <= 1'b0; // R16
      power_ctrl_present_reg  <= 1'b0; // R16
    end else if (wr_slot & ~cfg_locked) begin
      attn_button_present_reg <= reg_wdata[`LSS_SLOT_ATTN]; // R14
      power_ctrl_present_reg  <= reg_wdata[`LSS_SLOT_PWR]; // R15
    end
  end

  // configuration; lock bit sticks once set
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfg_reg <= `LSS_CFG_RESET;
    end else if (wr_cfg & ~cfg_locked) begin
      cfg_reg <= reg_wdata[`LSS_CFG_WIDTH-1:0];
    end
  end

  // assembled read words
  assign link_sts_word = {auto_bw_flag_reg,
                          bw_mgmt_flag_reg,
                          dl_active_flag_reg,
                          shared_refclk_reg,
                          training_active_reg,
                          training_failure_reg,
                          negotiated_lanes_reg,
                          current_rate_reg};
  // retrain always reads back zero
  assign link_ctl_word = {4'h0,
                          auto_irq_en_eff,
                          bw_irq_en_eff,
                          4'h0,
                          1'b0, // R18
                          5'h00};
  assign slot_cap_word = {30'h00000000,
                          power_ctrl_present_reg,
                          attn_button_present_reg};

  // read mux, unmapped addresses read zero
  always @* begin
    rd_data_next = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `LSS_ADDR_LINK_CTRL: begin
          rd_data_next = {16'h0000, link_ctl_word};
        end
        `LSS_ADDR_LINK_STS: begin
          rd_data_next = {16'h0000, link_sts_word};
        end
        `LSS_ADDR_SLOT_CAP: begin
          rd_data_next = slot_cap_word;
        end
        `LSS_ADDR_CONFIG: begin
          rd_data_next = {27'h0000000, cfg_reg};
        end
        default: begin
          rd_data_next = 32'h00000000;
        end
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data_reg <= 32'h00000000;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign reg_rdata       = rd_data_reg;
  assign retrain_request = retrain_request_reg;
  assign bw_mgmt_irq     = bw_mgmt_irq_reg;
  assign auto_bw_irq     = auto_bw_irq_reg;

endmodule

// >>> lss_defines.vh
// register map, field positions, reset values and counts for the link status bank
`ifndef LSS_DEFINES_VH
`define LSS_DEFINES_VH

// register byte addresses
`define LSS_ADDR_LINK_CTRL    8'h50
`define LSS_ADDR_LINK_STS     8'h52
`define LSS_ADDR_SLOT_CAP     8'h54
`define LSS_ADDR_CONFIG       8'h60

// link status fields
`define LSS_STS_RATE_LSB      0
`define LSS_STS_RATE_MSB      3
`define LSS_STS_LANES_LSB     4
`define LSS_STS_LANES_MSB     9
`define LSS_STS_TRAIN_FAIL    10
`define LSS_STS_TRAIN_ACT     11
`define LSS_STS_REFCLK        12
`define LSS_STS_DL_ACTIVE     13
`define LSS_STS_BW_MGMT       14
`define LSS_STS_AUTO_BW       15

// link control fields
`define LSS_CTL_RETRAIN       5
`define LSS_CTL_BW_IRQ_EN     10
`define LSS_CTL_AUTO_IRQ_EN   11

// slot capability fields
`define LSS_SLOT_ATTN         0
`define LSS_SLOT_PWR          1

// configuration register fields
`define LSS_CFG_BW_NOTIFY     0
`define LSS_CFG_DL_REPORT     1
`define LSS_CFG_SLOT_IMPL     2
`define LSS_CFG_COMPAT_11     3
`define LSS_CFG_LOCK          4
`define LSS_CFG_WIDTH         5

// reset values
`define LSS_RATE_RESET        4'h1
`define LSS_LANES_RESET       6'h00
`define LSS_CFG_RESET         5'h07

// counts
`define LSS_AUTO_OS_COUNT     4'h8
`define LSS_STRAP_LOAD_CNT    2'h2
`define LSS_STRAP_DONE_CNT    2'h3

`endif

// >>> lss_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module lss_sync #(
  parameter WIDTH = 1
) (
  input  wire             ref_clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // first stage feeds only the second stage
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule

// >>> lss_regs_sva.sv
// port-level checks for the link status bank
`timescale 1ns/100ps
module lss_regs_sva (
  input wire        ref_clk,
  input wire        reset,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire [3:0]  phy_rate,
  input wire [5:0]  phy_lanes,
  input wire        phy_train_error,
  input wire        phy_training,
  input wire        dl_active_in,
  input wire        dl_down,
  input wire        retrain_done,
  input wire        phy_fix_change,
  input wire        phy_auto_change,
  input wire        ts_valid,
  input wire        retrain_request,
  input wire        bw_mgmt_irq,
  input wire        auto_bw_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // status reads follow the inputs two edges back
  a_rate_mirror: assert property ($past(reg_rd) && $past(reg_addr) == 8'h52
    |-> reg_rdata[3:0] == $past(phy_rate, 2)) else $error("rate mismatch");
  a_lane_mirror: assert property ($past(reg_rd) && $past(reg_addr) == 8'h52
    |-> reg_rdata[9:4] == $past(phy_lanes, 2)) else $error("lanes mismatch");
  a_train_error: assert property ($past(reg_rd) && $past(reg_addr) == 8'h52
    && reg_rdata[10] |-> $past(phy_train_error, 2)) else $error("stray training error");
  a_train_flag: assert property ($past(reg_rd) && $past(reg_addr) == 8'h52
    |-> reg_rdata[11] == $past(phy_training, 2)) else $error("training bit mismatch");
  a_dl_active: assert property ($past(reg_rd) && $past(reg_addr) == 8'h52
    && reg_rdata[13] |-> $past(dl_active_in, 2)) else $error("stray link active");
  // retrain request and interrupt causes
  a_retrain_pulse: assert property (reg_wr && reg_addr == 8'h50 && reg_wdata[5]
    |=> retrain_request ##1 !retrain_request) else $error("retrain pulse wrong");
  a_bw_irq_cause: assert property (bw_mgmt_irq
    |-> ($past(retrain_done) || $past(phy_fix_change)) && !$past(dl_down)) else $error("bw irq uncaused");
  a_auto_irq_cause: assert property (auto_bw_irq
    |-> $past(phy_auto_change) || $past(ts_valid)) else $error("auto irq uncaused");
  // retrain bit never reads back as one
  a_retrain_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h50
    |-> !reg_rdata[5]) else $error("retrain bit read back");
endmodule
bind lss_regs lss_regs_sva chk (
  .ref_clk (ref_clk), .reset (reset), .reg_addr (reg_addr), .reg_wdata (reg_wdata), .reg_wr (reg_wr),
  .reg_rd (reg_rd), .reg_rdata (reg_rdata), .phy_rate (phy_rate), .phy_lanes (phy_lanes),
  .phy_train_error (phy_train_error), .phy_training (phy_training), .dl_active_in (dl_active_in),
  .dl_down (dl_down), .retrain_done (retrain_done), .phy_fix_change (phy_fix_change),
  .phy_auto_change (phy_auto_change), .ts_valid (ts_valid), .retrain_request (retrain_request),
  .bw_mgmt_irq (bw_mgmt_irq), .auto_bw_irq (auto_bw_irq)
);

// >>> lss_phy_model.sv
// far-end link model: answers retrain requests fast or slow
`timescale 1ns/100ps
module lss_phy_model (
  input  wire ref_clk,
  input  wire reset,
  input  wire retrain_request,
  input  wire slow,
  input  wire drop,
  output reg  retrain_done,
  output reg  dl_down,
  output reg  phy_training
);
  reg [3:0] cnt_reg;
  // recovery lasts 1 or 6 cycles, optionally through link down
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 4'h0;
      retrain_done <= 1'b0;
      dl_down <= 1'b0;
      phy_training <= 1'b0;
    end else begin
      retrain_done <= 1'b0;
      if (retrain_request) begin
        cnt_reg <= slow ? 4'h6 : 4'h1;
        phy_training <= 1'b1;
        dl_down <= drop;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          phy_training <= 1'b0;
          dl_down <= 1'b0;
          retrain_done <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> tb_lss_regs.sv
// self-checking bench for the link status bank
`timescale 1ns/100ps
module tb_lss_regs;
  reg         ref_clk = 1'b0, reset = 1'b1;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0, reg_rd = 1'b0;
  reg         up_port_refclk_strap = 1'b0, down_port_refclk_strap = 1'b1;
  reg  [3:0]  phy_rate = 4'h1;
  reg  [5:0]  phy_lanes = 6'h00;
  reg         phy_train_error = 1'b0, dl_active_in = 1'b0;
  reg         phy_fix_change = 1'b0, phy_auto_change = 1'b0;
  reg         ts_valid = 1'b0, ts_auto_change = 1'b0, slow = 1'b0, drop = 1'b0;
  wire [31:0] reg_rdata;
  wire        retrain_done, dl_down, phy_training, retrain_request, bw_mgmt_irq, auto_bw_irq;
  reg  [31:0] q;
  reg  [7:0]  cfg = 8'h07;
  reg         strap_e = 1'b1;
  integer     failures = 0, comparisons = 0, nbw = 0, nau = 0, cyc = 0, seed;

  wire [31:0] reg_rdata_up;
  reg  [31:0] qu;

  // downstream port under test
  lss_regs dut (
    .ref_clk (ref_clk), .reset (reset), .reg_addr (reg_addr), .reg_wdata (reg_wdata),
    .reg_wr (reg_wr), .reg_rd (reg_rd), .reg_rdata (reg_rdata),
    .up_port_refclk_strap (up_port_refclk_strap), .down_port_refclk_strap (down_port_refclk_strap),
    .phy_rate (phy_rate), .phy_lanes (phy_lanes), .phy_train_error (phy_train_error),
    .phy_training (phy_training), .dl_active_in (dl_active_in), .dl_down (dl_down),
    .retrain_done (retrain_done), .phy_fix_change (phy_fix_change), .phy_auto_change (phy_auto_change),
    .ts_valid (ts_valid), .ts_auto_change (ts_auto_change), .retrain_request (retrain_request),
    .bw_mgmt_irq (bw_mgmt_irq), .auto_bw_irq (auto_bw_irq)
  );
  // upstream port on the same inputs: other strap, no ordered-set flag
  lss_regs #(
    .UPSTREAM (1)
  ) dut_up (
    .ref_clk (ref_clk), .reset (reset), .reg_addr (reg_addr), .reg_wdata (reg_wdata),
    .reg_wr (reg_wr), .reg_rd (reg_rd), .reg_rdata (reg_rdata_up),
    .up_port_refclk_strap (up_port_refclk_strap), .down_port_refclk_strap (down_port_refclk_strap),
    .phy_rate (phy_rate), .phy_lanes (phy_lanes), .phy_train_error (phy_train_error),
    .phy_training (phy_training), .dl_active_in (dl_active_in), .dl_down (dl_down),
    .retrain_done (retrain_done), .phy_fix_change (phy_fix_change), .phy_auto_change (phy_auto_change),
    .ts_valid (ts_valid), .ts_auto_change (ts_auto_change), .retrain_request (),
    .bw_mgmt_irq (), .auto_bw_irq ()
  );
  // far end answering the downstream port's retrain requests
  lss_phy_model link (
    .ref_clk (ref_clk), .reset (reset), .retrain_request (retrain_request), .slow (slow), .drop (drop),
    .retrain_done (retrain_done), .dl_down (dl_down), .phy_training (phy_training)
  );

  // clock, interrupt counts and cycle ceiling
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (bw_mgmt_irq) nbw = nbw + 1;
    if (auto_bw_irq) nau = nau + 1;
    if (cyc == 3000) begin
      failures = failures + 1;
      print_verdict;
    end
  end

  task print_verdict;
    begin
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
      qu = reg_rdata_up;
      chk(q & m, e);
    end
  endtask
  task setcfg(input [7:0] v);
    begin
      wr_reg(8'h60, {24'h0, v});
      cfg = v;
    end
  endtask
  // expected status word from the driven inputs
  function [31:0] exp_sts();
    exp_sts = {18'h0, dl_active_in & cfg[1], strap_e, phy_training, phy_train_error & ~cfg[3], phy_lanes, phy_rate};
  endfunction
  task mirror_check;
    reg [31:0] r;
    begin
      repeat (10) begin
        r = $random(seed);
        @(posedge ref_clk);
        phy_rate <= r[6] ? 4'h2 : 4'h1;
        phy_lanes <= r[5:0];
        phy_train_error <= r[7];
        dl_active_in <= r[8];
        repeat (2) @(posedge ref_clk);
        rchk(8'h52, 32'h3FFF, exp_sts());
      end
    end
  endtask
  task ev_pulse(input [1:0] e);
    begin
      @(posedge ref_clk);
      {phy_auto_change, phy_fix_change} <= e;
      @(posedge ref_clk);
      {phy_auto_change, phy_fix_change} <= 2'b00;
      repeat (2) @(posedge ref_clk);
    end
  endtask
  task ts_burst(input integer n, input m);
    begin
      repeat (n) begin
        @(posedge ref_clk);
        ts_valid <= 1'b1;
        ts_auto_change <= m;
      end
      @(posedge ref_clk);
      ts_valid <= 1'b0;
    end
  endtask
  task wait_done;
    integer i;
    begin
      i = 0;
      while (!retrain_done && i < 40) begin
        @(posedge ref_clk);
        #1;
        i = i + 1;
      end
      repeat (2) @(posedge ref_clk);
    end
  endtask

  // main sequence
  initial begin
    seed = 32'h52EB;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rchk(8'h52, 32'h3FF, 32'h001);
    rchk(8'h54, 32'hFFFFFFFF, 32'h0);
    rchk(8'h50, 32'hFFFFFFFF, 32'h0);
    repeat (4) @(posedge ref_clk);
    rchk(8'h52, 32'h1000, 32'h1000);
    chk(qu & 32'h1000, 32'h0);
    wr_reg(8'h52, 32'h0);
    strap_e = 1'b0;
    mirror_check;
    wr_reg(8'h50, 32'h0C00);
    slow = 1'b1;
    wr_reg(8'h50, 32'h0C20);
    repeat (2) @(posedge ref_clk);
    rchk(8'h52, 32'h4800, 32'h0800);
    wait_done;
    rchk(8'h52, 32'hC800, 32'h4000);
    chk(nbw, 1);
    rchk(8'h50, 32'h0C20, 32'h0C00);
    wr_reg(8'h52, 32'h4000);
    rchk(8'h52, 32'h4000, 32'h0);
    slow = 1'b0;
    drop = 1'b1;
    wr_reg(8'h50, 32'h0C20);
    wait_done;
    rchk(8'h52, 32'h4000, 32'h0);
    ev_pulse(2'b01);
    rchk(8'h52, 32'hC000, 32'h4000);
    // event and one-to-clear write in the same cycle: set wins
    @(posedge ref_clk);
    phy_fix_change <= 1'b1;
    reg_addr <= 8'h52;
    reg_wdata <= 32'h4000;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    phy_fix_change <= 1'b0;
    reg_wr <= 1'b0;
    rchk(8'h52, 32'h4000, 32'h4000);
    ev_pulse(2'b10);
    wr_reg(8'h52, 32'h0);
    rchk(8'h52, 32'hC000, 32'hC000);
    chk(nau, 1);
    wr_reg(8'h52, 32'hC000);
    ts_burst(7, 1'b1);
    ts_burst(1, 1'b0);
    ts_burst(7, 1'b1);
    rchk(8'h52, 32'h8000, 32'h0);
    ts_burst(1, 1'b0);
    ts_burst(8, 1'b1);
    rchk(8'h52, 32'h8000, 32'h8000);
    chk(qu & 32'h8000, 32'h0);
    wr_reg(8'h52, 32'h8000);
    setcfg(8'h06);
    ev_pulse(2'b01);
    rchk(8'h52, 32'h4000, 32'h0);
    setcfg(8'h0D);
    ev_pulse(2'b10);
    rchk(8'h52, 32'hC000, 32'h0);
    mirror_check;
    chk(nbw + 16 * nau, 32'h22);
    setcfg(8'h03);
    wr_reg(8'h54, 32'h3);
    rchk(8'h54, 32'hFFFFFFFF, 32'h0);
    setcfg(8'h07);
    wr_reg(8'h54, 32'h1);
    rchk(8'h54, 32'hFFFFFFFF, 32'h1);
    wr_reg(8'h54, 32'h2);
    rchk(8'h54, 32'hFFFFFFFF, 32'h2);
    setcfg(8'h17);
    wr_reg(8'h54, 32'h1);
    rchk(8'h54, 32'hFFFFFFFF, 32'h2);
    rchk(8'h70, 32'hFFFFFFFF, 32'h0);
    print_verdict;
  end
endmodule
